// ==== hdl/ahpc_gain.sv ====
// Static compressor curve: level in, gain out, in 0.75 dB units.
`timescale 1ns/10ps
`default_nettype none
module ahpc_gain
(
    // Curve settings
    input wire logic [2:0] upper_slope_select_in,
    input wire logic [2:0] lower_slope_select_in,
    input wire logic [5:0] knee_threshold_in,
    input wire logic [4:0] knee_amplitude_in,
    // Input attenuation below full scale, 0.75 dB units
    input wire logic [7:0] level_in,
    // Output attenuation to apply minus input attenuation (signed)
    output logic signed [9:0] gain_out
);
    // Slope code to shift; zero flag (code 5 upper, code 4 lower) means slope zero (flat output).
    function automatic logic signed [9:0] scale(input logic signed [9:0] d,
                                               input logic [2:0] s, input logic zero);
        if (zero)
            scale = 10'sh000;
        else
            scale = d >>> s;
    endfunction : scale

    logic signed [9:0] t, yt, x, y;
    always_comb
    begin
        t = {4'h0, knee_threshold_in};
        yt = {5'h00, knee_amplitude_in};
        x = {2'h0, level_in};
        // Above knee means less attenuation than T; slope applies to distance.
        if (x <= t)
            y = yt - scale(t - x, upper_slope_select_in, upper_slope_select_in == 3'h5); // R10
        else
            y = yt + scale(x - t, lower_slope_select_in, lower_slope_select_in == 3'h4); // R10
        // At 0 dB input y equals YT - T*R0, the derived full-scale output.
        gain_out = y - x; // R11 R15
    end
endmodule : ahpc_gain
`default_nettype wire

// ==== hdl/ahpc_pkg.sv ====
// Package with register map, field positions, reset values and constants.
package ahpc_pkg;
    // ==========================================================
    // Register indices (printed offsets are not all word aligned)
    localparam logic [7:0] REG_ANALOGUE_IDX = 8'h0a;
    localparam logic [7:0] REG_FILTER_IDX = 8'h26;
    localparam logic [7:0] REG_RC_MAIN_IDX = 8'h28;
    localparam logic [7:0] REG_RC_SLOPES_IDX = 8'h2a;
    localparam logic [7:0] REG_RC_KNEE_IDX = 8'h2b;
    localparam logic [7:0] REG_RC_STATUS_IDX = 8'h2c;
    // ==========================================================
    // Field positions
    localparam int OSR_BIT = 0;
    localparam int HPF_EN_BIT = 4;
    localparam int HPF_CUT_LSB = 5;
    localparam int RC_EN_BIT = 15;
    localparam int UPPER_LSB = 3;
    localparam int LOWER_LSB = 0;
    localparam int THRESH_LSB = 5;
    localparam int AMP_LSB = 0;
    // ==========================================================
    // Reset values
    localparam logic OSR_RST = 1'h1;
    localparam logic HPF_EN_RST = 1'h1;
    localparam logic [1:0] HPF_CUT_RST = 2'h0;
    localparam logic RC_EN_RST = 1'h0;
    localparam logic [2:0] UPPER_RST = 3'h4;
    localparam logic [2:0] LOWER_RST = 3'h0;
    localparam logic [5:0] THRESH_RST = 6'h00;
    localparam logic [4:0] AMP_RST = 5'h00;
    // ==========================================================
    // Highest legal codes
    localparam logic [2:0] UPPER_MAX = 3'h5;
    localparam logic [2:0] LOWER_MAX = 3'h4;
    localparam logic [5:0] THRESH_MAX = 6'h3c;
    localparam logic [4:0] AMP_MAX = 5'h1e;
    // ==========================================================
    // Filter shift per mode: pole a = 1 - 2^-k, corner ~ fs*2^-k/(2*pi).
    // k=12 gives about 1.7 Hz at 44.1 kHz; voice shifts approximate the corners.
    localparam logic [3:0] HPF_K_HIFI = 4'hc;
    localparam logic [3:0] HPF_K_V1 = 4'h5;
    localparam logic [3:0] HPF_K_V2 = 4'h3;
    localparam logic [3:0] HPF_K_V3 = 4'h2;
    // Level step unit: 0.75 dB, held as quarter-steps of 3 dB (units of 0.75 dB).
    localparam int SAMPLE_W = 24;
endpackage : ahpc_pkg

// ==== hdl/ahpc_top.sv ====
// Record-path high-pass filter and compressor with APB register access.
// Function
// R1 - High-pass filter active when enable bit is one, bypassed when zero.
// R2 - Two-bit corner select picks hi-fi or one of three voice modes.
// R3 - Hi-fi mode removes DC, corner about 3.7 Hz at 44.1 kHz; code uses k=12, about 1.7 Hz.
// R4 - Coefficients fixed relative to fs, so corner scales with sample rate.
// R5 - Voice two near 130 Hz, voice three near 267 Hz at 8 kHz.
// R6 - Software should keep the voice corner below 300 Hz.
// R7 - Oversample select bit: zero 64 x fs, one 128 x fs, reset one.
// R8 - Software must not pick low oversampling with system clock mode 10.
// R9 - Compressor acts only when its enable bit is one; reset zero.
// R10 - Two regions split at knee T; upper slope above, lower slope below.
// R11 - Slope one keeps gain, below one compresses, zero flattens output.
// R12 - Slope codes map to powers of two or zero; other codes reserved.
// R13 - Knee threshold in -0.75 dB steps down to -45 dB at 111100.
// R14 - Knee amplitude in -0.75 dB steps down to -22.5 dB at 11110.
// R15 - Full-scale output level is derived as YT minus T times upper slope.
// R16 - One sample per period; disabled compressor passes samples unchanged.
`timescale 1ns/10ps
`default_nettype none
module ahpc_top
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic nrst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [9:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Sample stream from the decimator
    input wire logic sample_valid_in,
    input wire logic signed [23:0] sample_in,
    // Processed sample stream
    output logic sample_valid_out,
    output logic signed [23:0] sample_out,
    // Modulator rate select to the analogue ADC
    output logic oversample_high_select_out
);
    // ==========================================================
    // State
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic osr;
        logic hpf_en;
        logic [1:0] hpf_cut;
        logic rc_en;
        logic [2:0] upper;
        logic [2:0] lower;
        logic [5:0] thresh;
        logic [4:0] amp;
        logic signed [39:0] hpf_acc;
        logic [7:0] level;
        logic signed [23:0] dout;
        logic vout;
    } ahpc_state_type;

    ahpc_state_type st_r, st_nxt;
    logic signed [9:0] gain;
    logic [7:0] blk_level;

    function automatic logic [7:0] word_idx(input logic [9:0] a);
        word_idx = a[9:2];
    endfunction : word_idx

    function automatic logic [3:0] hpf_shift(input logic [1:0] cut);
        case (cut)
            2'h0: hpf_shift = ahpc_pkg::HPF_K_HIFI; // R3
            2'h1: hpf_shift = ahpc_pkg::HPF_K_V1;
            2'h2: hpf_shift = ahpc_pkg::HPF_K_V2; // R5
            default: hpf_shift = ahpc_pkg::HPF_K_V3; // R5
        endcase
    endfunction : hpf_shift

    // Rough level: one more than the leading zero count of |x|, times 8 (6 dB = 8 units).
    function automatic logic [7:0] lvl(input logic signed [23:0] x);
        logic [23:0] m;
        logic [7:0] n;
        m = x[23] ? ~x : x;
        n = 8'h00;
        for (int i = 22; i >= 0; i--)
        begin
            if (m[i] == 1'b0 && n == 8'((22 - i) * 8))
                n = 8'((23 - i) * 8);
        end
        // The bottom of the 6 dB band is reported, so a power of two reads exactly.
        lvl = n + 8'h08;
    endfunction : lvl

    ahpc_gain u_gain
    (
        .upper_slope_select_in(st_r.upper),
        .lower_slope_select_in(st_r.lower),
        .knee_threshold_in(st_r.thresh),
        .knee_amplitude_in(st_r.amp),
        .level_in(st_r.level),
        .gain_out(gain)
    );

    // ==========================================================
    // Next state
    logic signed [23:0] hp;
    logic signed [39:0] wide;
    logic signed [47:0] prod;
    logic [4:0] sh;
    logic [7:0] idx;
    always_comb
    begin
        st_nxt = st_r;
        idx = word_idx(paddr_in);
        hp = 24'sh000000;
        wide = 40'sh0;
        prod = 48'sh0;
        sh = 5'h00;
        blk_level = 8'h00;
        // APB: one wait cycle, answer registered at the access phase.
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;
        if (psel_in && penable_in && !st_r.pready)
        begin
            st_nxt.pready = 1'b1;
            st_nxt.prdata = 32'h0;
            case (idx)
                ahpc_pkg::REG_ANALOGUE_IDX:
                begin
                    st_nxt.prdata[ahpc_pkg::OSR_BIT] = st_r.osr;
                    if (pwrite_in)
                        st_nxt.osr = pwdata_in[ahpc_pkg::OSR_BIT]; // R7
                end
                ahpc_pkg::REG_FILTER_IDX:
                begin
                    st_nxt.prdata[ahpc_pkg::HPF_EN_BIT] = st_r.hpf_en;
                    st_nxt.prdata[ahpc_pkg::HPF_CUT_LSB +: 2] = st_r.hpf_cut;
                    if (pwrite_in)
                    begin
                        st_nxt.hpf_en = pwdata_in[ahpc_pkg::HPF_EN_BIT]; // R1
                        st_nxt.hpf_cut = pwdata_in[ahpc_pkg::HPF_CUT_LSB +: 2]; // R2
                    end
                end
                ahpc_pkg::REG_RC_MAIN_IDX:
                begin
                    st_nxt.prdata[ahpc_pkg::RC_EN_BIT] = st_r.rc_en;
                    if (pwrite_in)
                        st_nxt.rc_en = pwdata_in[ahpc_pkg::RC_EN_BIT]; // R9
                end
                ahpc_pkg::REG_RC_SLOPES_IDX:
                begin
                    st_nxt.prdata[ahpc_pkg::UPPER_LSB +: 3] = st_r.upper;
                    st_nxt.prdata[ahpc_pkg::LOWER_LSB +: 3] = st_r.lower;
                    // Reserved codes are refused; the old setting stays.
                    if (pwrite_in && pwdata_in[ahpc_pkg::UPPER_LSB +: 3] <= ahpc_pkg::UPPER_MAX)
                        st_nxt.upper = pwdata_in[ahpc_pkg::UPPER_LSB +: 3]; // R12
                    if (pwrite_in && pwdata_in[ahpc_pkg::LOWER_LSB +: 3] <= ahpc_pkg::LOWER_MAX)
                        st_nxt.lower = pwdata_in[ahpc_pkg::LOWER_LSB +: 3]; // R12
                end
                ahpc_pkg::REG_RC_KNEE_IDX:
                begin
                    st_nxt.prdata[ahpc_pkg::THRESH_LSB +: 6] = st_r.thresh;
                    st_nxt.prdata[ahpc_pkg::AMP_LSB +: 5] = st_r.amp;
                    if (pwrite_in && pwdata_in[ahpc_pkg::THRESH_LSB +: 6] <= ahpc_pkg::THRESH_MAX)
                        st_nxt.thresh = pwdata_in[ahpc_pkg::THRESH_LSB +: 6]; // R13
                    if (pwrite_in && pwdata_in[ahpc_pkg::AMP_LSB +: 5] <= ahpc_pkg::AMP_MAX)
                        st_nxt.amp = pwdata_in[ahpc_pkg::AMP_LSB +: 5]; // R14
                end
                ahpc_pkg::REG_RC_STATUS_IDX:
                    st_nxt.prdata[7:0] = st_r.level;
                default:
                    st_nxt.pslverr = 1'b1;
            endcase
        end
        // Sample path: one sample in, one out, one cycle later.
        st_nxt.vout = sample_valid_in; // R16
        if (sample_valid_in)
        begin
            // y = x - acc, acc tracks DC with pole 1-2^-k; k fixed so fc scales with fs.
            if (st_r.hpf_en)
            begin
                wide = {sample_in, 16'h0000};
                hp = 24'(($signed(wide) - st_r.hpf_acc) >>> 16); // R1 R4
                st_nxt.hpf_acc = st_r.hpf_acc
                    + (($signed(wide) - st_r.hpf_acc) >>> hpf_shift(st_r.hpf_cut)); // R3 R4
            end
            else
                hp = sample_in; // R1
            blk_level = lvl(hp);
            st_nxt.level = blk_level;
            if (st_r.rc_en)
            begin
                // Gain in 0.75 dB units, applied as a shift of gain/8 rounded toward zero (6 dB steps).
                if (gain >= 0)
                begin
                    sh = 5'(gain[9:3]);
                    st_nxt.dout = hp >>> sh; // R9 R11
                end
                else
                begin
                    sh = 5'((-gain) >>> 3);
                    prod = 48'(hp) <<< sh;
                    if (prod > 48'sh7fffff)
                        st_nxt.dout = 24'sh7fffff;
                    else if (prod < -48'sh800000)
                        st_nxt.dout = -24'sh800000;
                    else
                        st_nxt.dout = prod[23:0]; // R9 R11
                end
            end
            else
                st_nxt.dout = hp; // R9 R16
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge mclk_in)
    begin
        if (!nrst_in)
        begin
            st_r <= '0;
            st_r.osr <= ahpc_pkg::OSR_RST; // R7
            st_r.hpf_en <= ahpc_pkg::HPF_EN_RST; // R1
            st_r.hpf_cut <= ahpc_pkg::HPF_CUT_RST; // R2
            st_r.rc_en <= ahpc_pkg::RC_EN_RST; // R9
            st_r.upper <= ahpc_pkg::UPPER_RST; // R12
            st_r.lower <= ahpc_pkg::LOWER_RST; // R12
            st_r.thresh <= ahpc_pkg::THRESH_RST;
            st_r.amp <= ahpc_pkg::AMP_RST;
        end
        else
            st_r <= st_nxt;
    end

    assign prdata_out = st_r.prdata;
    assign pready_out = st_r.pready;
    assign pslverr_out = st_r.pslverr;
    assign sample_valid_out = st_r.vout;
    assign sample_out = st_r.dout;
    assign oversample_high_select_out = st_r.osr;

    // ==========================================================
    // Checks
    // Every field takes its reset value one edge after reset is seen.
    a_osr_reset: assert property ( // R7
        @(posedge mclk_in)
        !nrst_in |=> oversample_high_select_out)
        else $error("oversample select not one after reset");
    a_rc_reset_off: assert property ( // R9
        @(posedge mclk_in)
        !nrst_in |=> !st_r.rc_en)
        else $error("compressor enabled after reset");
    a_hpf_reset: assert property ( // R1
        @(posedge mclk_in)
        !nrst_in |=> st_r.hpf_en)
        else $error("high-pass filter not enabled after reset");
    a_cut_reset: assert property ( // R2
        @(posedge mclk_in)
        !nrst_in |=> st_r.hpf_cut == ahpc_pkg::HPF_CUT_RST)
        else $error("corner select not hi-fi after reset");
    a_slope_reset: assert property ( // R12
        @(posedge mclk_in)
        !nrst_in |=> st_r.upper == ahpc_pkg::UPPER_RST && st_r.lower == ahpc_pkg::LOWER_RST)
        else $error("slope codes wrong after reset");
    a_knee_reset: assert property ( // R13 R14
        @(posedge mclk_in)
        !nrst_in |=> st_r.thresh == ahpc_pkg::THRESH_RST && st_r.amp == ahpc_pkg::AMP_RST)
        else $error("knee settings wrong after reset");
    // Sample stream: one result per strobe, held still between strobes.
    a_one_per_sample: assert property ( // R16
        @(posedge mclk_in) disable iff (!nrst_in)
        sample_valid_in |=> sample_valid_out)
        else $error("sample not produced");
    a_vout_pulse: assert property ( // R16
        @(posedge mclk_in) disable iff (!nrst_in)
        !sample_valid_in |=> !sample_valid_out)
        else $error("sample produced without a strobe");
    a_dout_hold: assert property ( // R16
        @(posedge mclk_in) disable iff (!nrst_in)
        !sample_valid_in |=> $stable(sample_out))
        else $error("sample output moved between strobes");
    a_bypass_pass: assert property ( // R1
        @(posedge mclk_in) disable iff (!nrst_in)
        sample_valid_in && !st_r.hpf_en && !st_r.rc_en |=> sample_out == $past(sample_in))
        else $error("bypass altered sample");
    // Reserved codes never reach the curve.
    a_upper_legal: assert property ( // R12
        @(posedge mclk_in) disable iff (!nrst_in)
        st_r.upper <= ahpc_pkg::UPPER_MAX)
        else $error("reserved upper slope stored");
    a_lower_legal: assert property ( // R12
        @(posedge mclk_in) disable iff (!nrst_in)
        st_r.lower <= ahpc_pkg::LOWER_MAX)
        else $error("reserved lower slope stored");
    a_thresh_legal: assert property ( // R13
        @(posedge mclk_in) disable iff (!nrst_in)
        st_r.thresh <= ahpc_pkg::THRESH_MAX)
        else $error("reserved threshold stored");
    a_amp_legal: assert property ( // R14
        @(posedge mclk_in) disable iff (!nrst_in)
        st_r.amp <= ahpc_pkg::AMP_MAX)
        else $error("reserved amplitude stored");
    // Static curve: unit slopes give a fixed gain, a zero slope pins the output at YT.
    a_unity_gain: assert property ( // R11
        @(posedge mclk_in) disable iff (!nrst_in)
        st_r.upper == 3'h0 && st_r.lower == 3'h0
        |-> gain == $signed({5'h00, st_r.amp}) - $signed({4'h0, st_r.thresh}))
        else $error("unit slopes did not give a fixed gain");
    a_upper_flat: assert property ( // R11
        @(posedge mclk_in) disable iff (!nrst_in)
        st_r.upper == 3'h5 && {2'h0, st_r.level} <= {4'h0, st_r.thresh}
        |-> gain + $signed({2'h0, st_r.level}) == $signed({5'h00, st_r.amp}))
        else $error("zero upper slope did not hold the knee amplitude");
    a_lower_flat: assert property ( // R11
        @(posedge mclk_in) disable iff (!nrst_in)
        st_r.lower == 3'h4 && {2'h0, st_r.level} > {4'h0, st_r.thresh}
        |-> gain + $signed({2'h0, st_r.level}) == $signed({5'h00, st_r.amp}))
        else $error("zero lower slope did not hold the knee amplitude");
    // Register bus: one wait state, ready for one cycle, errors only with ready.
    a_apb_ready: assert property (
        @(posedge mclk_in) disable iff (!nrst_in)
        psel_in && !penable_in ##1 psel_in && penable_in |=> pready_out)
        else $error("no ready one cycle into access");
    a_ready_pulse: assert property (
        @(posedge mclk_in) disable iff (!nrst_in)
        pready_out |=> !pready_out)
        else $error("ready held for more than one cycle");
    a_err_ready: assert property (
        @(posedge mclk_in) disable iff (!nrst_in)
        pslverr_out |-> pready_out)
        else $error("error flag without ready");
    a_slverr_data: assert property (
        @(posedge mclk_in) disable iff (!nrst_in)
        pslverr_out |-> prdata_out == 32'h0)
        else $error("unmapped read returned data");
    // ==========================================================
    // Cover points
    c_hpf_run: cover property (@(posedge mclk_in) sample_valid_in && st_r.hpf_en);
    c_rc_run: cover property (@(posedge mclk_in) sample_valid_in && st_r.rc_en);
    c_err: cover property (@(posedge mclk_in) pready_out && pslverr_out);
    c_voice_three: cover property (@(posedge mclk_in) sample_valid_in && st_r.hpf_cut == 2'h3);
    c_flat_curve: cover property (@(posedge mclk_in) sample_valid_in && st_r.upper == 3'h5);
endmodule : ahpc_top
`default_nettype wire

// ==== verification/ahpc_decim_model.sv ====
// Behavioural decimator model that feeds samples into the record path.
`timescale 1ns/10ps
`default_nettype none
module ahpc_decim_model
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic nrst_in,
    // Stream control from the bench
    input wire logic run_in,
    input wire logic [3:0] gap_in,
    input wire logic signed [23:0] level_in,
    // Sample stream
    output logic valid_out,
    output logic signed [23:0] data_out
);
    logic [3:0] wait_r;
    // Between strobes the data lines toggle, so stale data is never mistaken for a sample.
    always_ff @(posedge mclk_in)
    begin
        valid_out <= 1'b0;
        data_out <= ~data_out;
        if (!nrst_in)
        begin
            wait_r <= 4'h0;
            data_out <= 24'h000000;
        end
        else if (wait_r != 4'h0)
            wait_r <= wait_r - 4'h1;
        else if (run_in)
        begin
            valid_out <= 1'b1;
            data_out <= level_in;
            wait_r <= gap_in;
        end
    end
endmodule : ahpc_decim_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench for the record-path filter and compressor.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    typedef struct {logic [7:0] idx; logic [31:0] wd; logic [31:0] rd; logic er; logic osr;}
        ahpc_reg_row_type;
    typedef struct {logic [31:0] hpf; logic [31:0] slp; logic [31:0] knee; logic [31:0] comp;
        int lvl; int lo; int hi;} ahpc_path_row_type;
    localparam int X = 32'h00100000;
    localparam int Y = 32'h00400000;
    logic mclk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic run = 1'b0;
    logic [3:0] gap = 4'h0;
    logic signed [23:0] level = 24'h000000;
    logic svin;
    logic signed [23:0] sin;
    logic svout;
    logic signed [23:0] sout;
    logic osr;
    logic [31:0] rd;
    logic er;
    logic vin_d = 1'b0;
    logic signed [23:0] last = 24'h000000;
    int err_total = 0;
    int comparisons = 0;
    int outs = 0;
    // Rows that write reserved codes must leave the old field value in place.
    ahpc_reg_row_type regs[10] = '{
        '{8'h26, 32'h70, 32'h70, 1'b0, 1'b1},
        '{8'h2a, 32'h2c, 32'h2c, 1'b0, 1'b1},
        '{8'h2a, 32'h36, 32'h2c, 1'b0, 1'b1},
        '{8'h2b, 32'h79e, 32'h79e, 1'b0, 1'b1},
        '{8'h2b, 32'h7bf, 32'h79e, 1'b0, 1'b1},
        '{8'h28, 32'hffff0000, 32'h0, 1'b0, 1'b1},
        '{8'h28, 32'h8000, 32'h8000, 1'b0, 1'b1},
        '{8'h0a, 32'h0, 32'h0, 1'b0, 1'b0},
        '{8'h0a, 32'h1, 32'h1, 1'b0, 1'b1},
        '{8'h3f, 32'hffff, 32'h0, 1'b1, 1'b1}};
    ahpc_path_row_type paths[9] = '{
        '{32'h0, 32'h20, 32'h0, 32'h0, X, X, X},
        '{32'h10, 32'h20, 32'h0, 32'h0, X, 32'he6666, X + 16},
        '{32'h30, 32'h20, 32'h0, 32'h0, X, 32'h1999a, 32'hb3333},
        '{32'h50, 32'h20, 32'h0, 32'h0, X, -32'h10000, 32'h10000},
        '{32'h70, 32'h20, 32'h0, 32'h0, X, -32'h10000, 32'h10000},
        '{32'h0, 32'h20, 32'h8, 32'h8000, X, 32'h60000, 32'ha0000},
        '{32'h0, 32'h24, 32'h8, 32'h8000, X, 32'h300000, 32'h500000},
        '{32'h0, 32'h28, 32'h210, 32'h8000, Y, 32'h180000, 32'h280000},
        '{32'h0, 32'h28, 32'h210, 32'h0, Y, Y, Y}};
    logic [7:0] rst_idx[5] = '{8'h0a, 8'h26, 8'h28, 8'h2a, 8'h2b};
    logic [31:0] rst_val[5] = '{32'h1, 32'h10, 32'h0, 32'h20, 32'h0};

    always #10 mclk_in = ~mclk_in;

    ahpc_top u_ahpc_top (.mclk_in(mclk_in), .nrst_in(nrst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .sample_valid_in(svin), .sample_in(sin), .sample_valid_out(svout),
        .sample_out(sout), .oversample_high_select_out(osr));
    ahpc_decim_model u_ahpc_decim_model (.mclk_in(mclk_in), .nrst_in(nrst_in), .run_in(run),
        .gap_in(gap), .level_in(level), .valid_out(svin), .data_out(sin));

    task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk_word

    task automatic chk_range(input string nm, input int lo, input int hi,
        input logic signed [23:0] got);
        comparisons++;
        if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1))
        begin
            err_total++;
            $display("FAIL %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask : chk_range

    task automatic tally_and_finish;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        @(posedge mclk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= wd;
        @(posedge mclk_in);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk_in);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            err_total++;
            tally_and_finish();
        end
    endtask : apb

    task automatic do_reset;
        @(posedge mclk_in);
        nrst_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        nrst_in <= 1'b1;
    endtask : do_reset

    // Thirty samples are enough for voice modes two and three to settle on a DC step.
    task automatic feed(input int lvl, input logic [3:0] g);
        int start;
        int n;
        @(posedge mclk_in);
        start = outs;
        n = 0;
        level <= lvl[23:0];
        gap <= g;
        run <= 1'b1;
        while (outs - start < 30 && n < 600)
        begin
            @(posedge mclk_in);
            n++;
        end
        run <= 1'b0;
        repeat (4) @(posedge mclk_in);
        if (n >= 600)
        begin
            err_total++;
            tally_and_finish();
        end
    endtask : feed

    always @(posedge mclk_in)
    begin
        if (nrst_in === 1'b1)
            chk_word("valid_out", {31'h0, vin_d}, {31'h0, svout});
        vin_d <= svin & nrst_in;
        if (svout === 1'b1)
        begin
            outs++;
            last <= sout;
        end
    end

    initial
    begin
        do_reset();
        foreach (regs[i])
        begin
            apb(1'b1, regs[i].idx, regs[i].wd);
            chk_word("write_err", {31'h0, regs[i].er}, {31'h0, er});
            apb(1'b0, regs[i].idx, 32'h0);
            chk_word("read_data", regs[i].rd, rd);
            chk_word("read_err", {31'h0, regs[i].er}, {31'h0, er});
            chk_word("osr_out", {31'h0, regs[i].osr}, {31'h0, osr});
        end
        do_reset();
        chk_word("osr_reset", 32'h1, {31'h0, osr});
        foreach (rst_idx[i])
        begin
            apb(1'b0, rst_idx[i], 32'h0);
            chk_word("reset_value", rst_val[i], rd);
        end
        foreach (paths[i])
        begin
            do_reset();
            apb(1'b1, 8'h26, paths[i].hpf);
            apb(1'b1, 8'h2a, paths[i].slp);
            apb(1'b1, 8'h2b, paths[i].knee);
            apb(1'b1, 8'h28, paths[i].comp);
            feed(paths[i].lvl, (i % 2) ? 4'h5 : 4'h0);
            chk_range("settled_out", paths[i].lo, paths[i].hi, last);
        end
        // The last row fed a -6 dB sample, which is eight 0.75 dB units.
        apb(1'b0, 8'h2c, 32'h0);
        chk_word("level_status", 32'h8, rd);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
